// *** bench/ldd_host_model.sv ***
/*
 Model of the serial-interface side that reads and writes the diagnostic
 registers through the decoded strobe, address and write data.
 Assumes the caller sits on the rising edge of clock; rd_mark flags the
 cycle in which a read address is presented.
*/
`timescale 1ns/1ps

module ldd_host_model (
   input  wire logic       clock,
   output logic            reg_wr_en,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wr_data,
   output logic            rd_mark
);
   initial begin
      reg_wr_en   = 1'b0;
      reg_addr    = 8'h00;
      reg_wr_data = 8'h00;
      rd_mark     = 1'b0;
   end

   // One-cycle strobe; data is scrambled afterwards so nothing relies on a stale bus
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr_en   <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= d;
      @(posedge clock);
      reg_wr_en   <= 1'b0;
      reg_wr_data <= ~d;
   endtask

   // No read strobe exists, so the address alone selects what comes back
   task automatic read_reg(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      rd_mark  <= 1'b1;
      @(posedge clock);
      rd_mark  <= 1'b0;
   endtask
endmodule

// *** bench/tb_top.sv ***
/*
 Self-checking bench of the diagnostic status block with shortened timers.
 Assumes ldd_host_model drives the register side; pins are driven here.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, (e), (g)); end end

module tb_top;
   import ldd_pkg::*;
   logic       clock = 1'b0;
   logic       rst_b = 1'b0;
   logic [2:0] pwm_pin = 3'h0;
   logic       gate_supply_at_target = 1'b0;
   logic       vin_above_uv = 1'b0;
   logic [2:0] current_at_target = 3'h0;
   logic [2:0] headroom_low = 3'h0;
   logic [2:0] channel_on = 3'h7;
   logic [2:0] gate_drive_high = 3'h0;
   logic       clear_errors = 1'b0;
   logic       nv_write_rejected = 1'b0;
   logic       nv_access_done = 1'b0;
   logic       reg_wr_en, rd_mark, chk_q = 1'b0;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data, exp_v;
   logic       gate_supply_fault, gate_supply_good, input_supply_status;
   logic       gate_driver_enable, gate_supply_reg_enable, vled_update_enable;
   logic [2:0] channel_gate_enable, b, m;
   logic [7:0] exp_q[$];
   int         n_mismatch = 0;
   int         n_tests = 0;
   int         seed = 66807;

   ldd_host_model ldd_host_model_inst (.clock(clock), .reg_wr_en(reg_wr_en),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .rd_mark(rd_mark));

   ldd_diag #(.START_WAIT_CYCLES(20), .RUN_WAIT_CYCLES(8), .GATE_HIGH_CYCLES(6)) ldd_diag_inst (
      .clock(clock), .rst_b(rst_b), .pwm_pin(pwm_pin),
      .gate_supply_at_target(gate_supply_at_target), .vin_above_uv(vin_above_uv),
      .current_at_target(current_at_target), .headroom_low(headroom_low),
      .channel_on(channel_on), .gate_drive_high(gate_drive_high),
      .clear_errors(clear_errors), .nv_write_rejected(nv_write_rejected),
      .nv_access_done(nv_access_done), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
      .gate_supply_fault(gate_supply_fault), .gate_supply_good(gate_supply_good),
      .input_supply_status(input_supply_status), .gate_driver_enable(gate_driver_enable),
      .gate_supply_reg_enable(gate_supply_reg_enable),
      .vled_update_enable(vled_update_enable), .channel_gate_enable(channel_gate_enable));

   initial begin
      forever #12.5 clock = ~clock;
   end

   // Read data lands one edge after the address, so compare one edge after that
   always @(posedge clock) begin
      chk_q <= rd_mark;
      if (chk_q) begin
         exp_v = exp_q.pop_front();
         `CHK("reg_rd_data", exp_v, reg_rd_data)
      end
   end

   task automatic complete_run;
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      ldd_host_model_inst.read_reg(a);
   endtask

   // Three spare cycles let a copy request finish before the next read
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ldd_host_model_inst.write_reg(a, d);
      wait_clk(3);
   endtask

   // Pins pass a two-flop synchroniser, so six cycles cover every effect
   task automatic pulse_cur(input logic [2:0] v);
      @(posedge clock);
      current_at_target <= v;
      wait_clk(6);
      current_at_target <= 3'h0;
      wait_clk(6);
   endtask

   task automatic pwm_set(input logic [2:0] v);
      @(posedge clock);
      pwm_pin <= v;
      wait_clk(6);
   endtask

   task automatic clear_fault;
      @(posedge clock);
      gate_supply_at_target <= 1'b1;
      clear_errors          <= 1'b1;
      @(posedge clock);
      clear_errors <= 1'b0;
      wait_clk(8);
   endtask

   initial begin
      #(25 * 20000);
      n_mismatch++;
      complete_run();
   end

   initial begin
      wait_clk(3);
      rst_b <= 1'b1;
      rd(8'h06, 8'h00);
      rd(8'h35, 8'h00);
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h00);
      rd(8'h10, 8'h00);
      // Start phase allows the long wait, so no fault yet at 14 cycles
      @(posedge clock);
      vin_above_uv <= 1'b1;
      wait_clk(14);
      @(negedge clock);
      `CHK("fault", 1'b0, gate_supply_fault)
      wait_clk(14);
      @(negedge clock);
      `CHK("fault", 1'b1, gate_supply_fault)
      `CHK("good", 1'b0, gate_supply_good)
      `CHK("drv", 1'b0, gate_driver_enable)
      `CHK("reg_en", 1'b0, gate_supply_reg_enable)
      `CHK("vled", 1'b0, vled_update_enable)
      wr(8'h37, 8'($random(seed)));
      rd(8'h37, 8'h10);
      clear_fault();
      @(negedge clock);
      `CHK("fault", 1'b0, gate_supply_fault)
      `CHK("good", 1'b1, gate_supply_good)
      `CHK("drv", 1'b1, gate_driver_enable)
      `CHK("vled", 1'b1, vled_update_enable)
      `CHK("vin", 1'b1, input_supply_status)
      rd(8'h37, 8'h08);
      // In operation the short wait applies: 14 cycles already trip it
      @(posedge clock);
      gate_supply_at_target <= 1'b0;
      wait_clk(14);
      @(negedge clock);
      `CHK("fault", 1'b1, gate_supply_fault)
      clear_fault();
      for (int i = 0; i < 3; i++) begin
         b = 3'h1 << i;
         pulse_cur(b);
         rd(8'h35, {2'h0, b, 3'h0});
         wr(8'h06, {5'h00, b});
         rd(8'h37, {5'h01, b});
         rd(8'h35, 8'h00);
         rd(8'h06, 8'h00);
         pwm_set(b);
         pwm_set(3'h0);
         rd(8'h37, 8'h08);
         pwm_set(b);
         pulse_cur(b);
         pwm_set(3'h0);
         rd(8'h37, {5'h01, b});
         rd(8'h35, 8'h00);
         rd(8'h36, {5'h00, b});
         wr(8'h36, 8'($random(seed)));
         rd(8'h36, 8'h00);
         // Gate held high with PWM high drops the current-cycle flag
         pwm_set(b);
         pulse_cur(b);
         rd(8'h35, {2'h0, b, 3'h0});
         @(posedge clock);
         gate_drive_high <= b;
         wait_clk(12);
         gate_drive_high <= 3'h0;
         rd(8'h35, 8'h00);
         pwm_set(3'h0);
         wr(8'h36, 8'h00);
         pulse_cur(b);
         wr(8'h06, {5'h00, b});
         @(posedge clock);
         headroom_low <= b;
         wait_clk(6);
         @(negedge clock);
         `CHK("gate_en", 3'h7 ^ b, channel_gate_enable)
         rd(8'h35, {5'h00, b});
         rd(8'h37, 8'h08);
         @(posedge clock);
         headroom_low <= 3'h0;
         wait_clk(6);
         @(negedge clock);
         `CHK("gate_en", 3'h7, channel_gate_enable)
         rd(8'h35, {5'h00, b});
         wr(8'h35, 8'($random(seed)));
         rd(8'h35, 8'h00);
      end
      // An off channel keeps its last headroom sample, so a clear sets it again
      @(posedge clock);
      headroom_low <= 3'h1;
      wait_clk(6);
      channel_on   <= 3'h6;
      headroom_low <= 3'h0;
      wait_clk(6);
      @(negedge clock);
      `CHK("gate_en", 3'h6, channel_gate_enable)
      wr(8'h35, 8'($random(seed)));
      rd(8'h35, 8'h01);
      @(posedge clock);
      channel_on <= 3'h7;
      wait_clk(6);
      wr(8'h35, 8'h00);
      rd(8'h35, 8'h00);
      @(posedge clock);
      nv_write_rejected <= 1'b1;
      @(posedge clock);
      nv_write_rejected <= 1'b0;
      rd(8'h36, 8'h10);
      @(posedge clock);
      nv_access_done <= 1'b1;
      @(posedge clock);
      nv_access_done <= 1'b0;
      rd(8'h36, 8'h18);
      wr(8'h36, 8'($random(seed)));
      rd(8'h36, 8'h00);
      m = 3'($random(seed));
      pwm_set(m);
      rd(8'h36, {5'h00, m});
      pwm_set(3'h0);
      rd(8'h36, {5'h00, m});
      wr(8'h36, 8'h00);
      // Undervoltage wipes both current flag sets and the good flag
      pulse_cur(3'h7);
      wr(8'h06, 8'h07);
      pulse_cur(3'h7);
      @(posedge clock);
      vin_above_uv <= 1'b0;
      wait_clk(6);
      @(negedge clock);
      `CHK("good", 1'b0, gate_supply_good)
      `CHK("drv", 1'b0, gate_driver_enable)
      rd(8'h37, 8'h00);
      rd(8'h35, 8'h00);
      // Off mode through reset clears a standing fault
      @(posedge clock);
      vin_above_uv          <= 1'b1;
      gate_supply_at_target <= 1'b0;
      wait_clk(30);
      @(negedge clock);
      `CHK("fault", 1'b1, gate_supply_fault)
      @(posedge clock);
      rst_b <= 1'b0;
      wait_clk(2);
      rst_b <= 1'b1;
      @(negedge clock);
      `CHK("fault", 1'b0, gate_supply_fault)
      wait_clk(4);
      complete_run();
   end
endmodule

// *** design/ldd_diag.sv ***
/*
 Diagnostic status registers of a three-channel LED buck driver: gate
 supply fault and good, current reached flags, copy requests, memory
 access and PWM toggle flags, low headroom flags with gate cut-off.
 Assumes the serial interface decodes commands into reg_wr_en pulses
 with reg_addr and reg_wr_data, and returns reg_rd_data one cycle after
 reg_addr is presented. rst_b covers power-on and the enable pin low.
*/
`timescale 1ns/1ps
`include "ldd_params.svh"

// Summary of operation
// - Gate supply fault sets after 12 ms at start-up, 1 ms in operation.
// - Fault turns off gate drivers and regulator, clears good, stops current.
// - Fault stops updates of LED voltage measurements.
// - Fault clears only by clear-errors, off mode, or power-on reset.
// - Good sets when supply regulated; clears on undervoltage or fault.
// - Last-cycle flag refreshes on PWM falling edge or copy request.
// - Last-cycle flag clears on undervoltage or that channel's low headroom.
// - Copy request moves current flag to last, clears current, self-clears.
// - Access-failed flag sets on rejected write; diag 2 write clears it.
// - Access-done flag sets on completed access; diag 2 write clears it.
// - Toggle flag sets on PWM level change until diag 2 written.
// - Low headroom while on and input above undervoltage cuts gate and sets flag.
// - Gate resumes when headroom returns above threshold.
// - Headroom flags sticky until diag 3 write; may re-set from last sample.
// - Current-cycle flag sets when target current reached.
// - Current-cycle flag clears on fall, undervoltage, copy, long gate high.
// - Diag 3: current-cycle flags bits 5:3, headroom flags 2:0.
// - Diag 2: failed bit 4, done bit 3, toggle flags 2:0.
// - Diag 1: fault bit 4, good bit 3, last-cycle flags 2:0.
module ldd_diag
   import ldd_pkg::*;
#(
   parameter int unsigned START_WAIT_CYCLES = ldd_us_to_cycles(`LDD_START_WAIT_US),
   parameter int unsigned RUN_WAIT_CYCLES   = ldd_us_to_cycles(`LDD_RUN_WAIT_US),
   parameter int unsigned GATE_HIGH_CYCLES  = ldd_us_to_cycles(`LDD_GATE_HIGH_US)
) (
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic [2:0] pwm_pin,
   input  wire logic       gate_supply_at_target,
   input  wire logic       vin_above_uv,
   input  wire logic [2:0] current_at_target,
   input  wire logic [2:0] headroom_low,
   input  wire logic [2:0] channel_on,
   input  wire logic [2:0] gate_drive_high,
   input  wire logic       clear_errors,
   input  wire logic       nv_write_rejected,
   input  wire logic       nv_access_done,
   input  wire logic       reg_wr_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wr_data,
   output logic      [7:0] reg_rd_data,
   output logic            gate_supply_fault,
   output logic            gate_supply_good,
   output logic            input_supply_status,
   output logic            gate_driver_enable,
   output logic            gate_supply_reg_enable,
   output logic            vled_update_enable,
   output logic      [2:0] channel_gate_enable
);

   localparam logic [`LDD_FAULT_CNT_W-1:0] START_LIM =
      `LDD_FAULT_CNT_W'(START_WAIT_CYCLES - 1);
   localparam logic [`LDD_FAULT_CNT_W-1:0] RUN_LIM =
      `LDD_FAULT_CNT_W'(RUN_WAIT_CYCLES - 1);

   ldd_state_t  st_q;
   ldd_state_t  st_d;
   logic [10:0] sync_q;
   logic [2:0]  pwm_s;
   logic        gs_at_s;
   logic        vin_s;
   logic [2:0]  cur_at_s;
   logic [2:0]  hl_s;
   logic [2:0]  gate_tmo;
   logic [2:0]  pwm_fall;
   logic [2:0]  pwm_chg;
   logic        uv_event;
   logic [2:0]  lh_event;

   function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                   input logic [7:0] target);
      return en && (a == target);
   endfunction

   // Pins and analog comparator outputs all come from outside the clock
   ldd_sync #(.W(11)) u_sync (
      .clock (clock),
      .rst_b (rst_b),
      .d     ({pwm_pin, gate_supply_at_target, vin_above_uv,
               current_at_target, headroom_low}),
      .q     (sync_q)
   );

   assign pwm_s    = sync_q[10:8];
   assign gs_at_s  = sync_q[7];
   assign vin_s    = sync_q[6];
   assign cur_at_s = sync_q[5:3];
   assign hl_s     = sync_q[2:0];

   for (genvar i = 0; i < 3; i++) begin : g_tmr
      ldd_gate_timer #(.LIMIT(GATE_HIGH_CYCLES)) u_tmr (
         .clock     (clock),
         .rst_b     (rst_b),
         .gate_high (gate_drive_high[i]),
         .pwm_high  (pwm_s[i]),
         .timeout   (gate_tmo[i])
      );
   end

   assign pwm_fall = st_q.pwm_prev & ~pwm_s;
   assign pwm_chg  = st_q.pwm_prev ^ pwm_s;
   assign uv_event = st_q.vin_prev & ~vin_s;

   always_comb begin
      logic       wr_copy;
      logic       wr_d2;
      logic       wr_d3;
      logic       sampling;
      wr_copy  = wr_hit(reg_wr_en, reg_addr, `LDD_ADDR_COPY);
      wr_d2    = wr_hit(reg_wr_en, reg_addr, `LDD_ADDR_DIAG2);
      wr_d3    = wr_hit(reg_wr_en, reg_addr, `LDD_ADDR_DIAG3);
      sampling = 1'b0;
      lh_event = '0;
      st_d     = st_q;
      st_d.pwm_prev = pwm_s;
      st_d.vin_prev = vin_s;

      // Gate supply supervision; undervoltage holds off both flags
      unique case (st_q.gs)
         LDD_GS_START, LDD_GS_RUN: begin
            if (!vin_s) begin
               st_d.gs     = LDD_GS_START;
               st_d.gs_cnt = '0;
               st_d.good   = 1'b0;
            end else if (gs_at_s) begin
               st_d.gs     = LDD_GS_RUN;
               st_d.gs_cnt = '0;
               st_d.good   = 1'b1;
            end else if (st_q.gs_cnt ==
                         ((st_q.gs == LDD_GS_START) ? START_LIM : RUN_LIM)) begin
               st_d.gs    = LDD_GS_FAULT;
               st_d.fault = 1'b1;
               st_d.good  = 1'b0;
            end else begin
               st_d.gs_cnt = st_q.gs_cnt + 1'b1;
            end
         end
         LDD_GS_FAULT: begin
            st_d.good = 1'b0;
            if (clear_errors) begin
               st_d.gs     = LDD_GS_START;
               st_d.fault  = 1'b0;
               st_d.gs_cnt = '0;
            end
         end
         default: begin
            st_d.gs     = LDD_GS_FAULT;
            st_d.fault  = 1'b1;
            st_d.good   = 1'b0;
            st_d.gs_cnt = '0;
         end
      endcase
      // Drivers and regulator stay off through a fault, leaving only the bus
      st_d.drv_en  = vin_s && (st_d.gs != LDD_GS_FAULT);
      st_d.vled_en = st_d.good && !st_d.fault;

      for (int i = 0; i < 3; i++) begin
         // Low headroom; outside monitoring the last sample is kept
         sampling = channel_on[i] && vin_s;
         if (sampling) begin
            st_d.lh_sample[i] = hl_s[i];
         end
         st_d.cut[i]     = sampling && hl_s[i];
         lh_event[i]     = st_d.cut[i] && !st_q.cut[i];
         st_d.lh_flag[i] = st_d.lh_sample[i] ||
                           (st_q.lh_flag[i] && !wr_d3);
         st_d.gate_en[i] = st_d.drv_en && channel_on[i] && !st_d.cut[i];

         // Last-cycle flag: copy on falling edge or request, clear on events
         if (uv_event || lh_event[i]) begin
            st_d.last[i] = 1'b0;
         end else if (pwm_fall[i] || st_q.copy[i]) begin
            st_d.last[i] = st_q.cur[i];
         end

         // Current-cycle flag: a clear wins over a set in the same cycle
         if (pwm_fall[i] || uv_event || st_q.copy[i] || gate_tmo[i]) begin
            st_d.cur[i] = 1'b0;
         end else if (cur_at_s[i]) begin
            st_d.cur[i] = 1'b1;
         end

         // A new request in the cycle of the self-clear is kept
         st_d.copy[i] = (wr_copy && reg_wr_data[i]);

         st_d.toggle[i] = pwm_chg[i] || (st_q.toggle[i] && !wr_d2);
      end

      st_d.nv_fail = nv_write_rejected || (st_q.nv_fail && !wr_d2);
      st_d.nv_done = nv_access_done || (st_q.nv_done && !wr_d2);

      // Read data is registered; unmapped offsets read zero
      st_d.rd_data = `LDD_RST_BYTE;
      unique case (reg_addr)
         `LDD_ADDR_COPY: st_d.rd_data[2:0] = st_q.copy;
         `LDD_ADDR_DIAG3: begin
            st_d.rd_data[`LDD_D3_CUR_LSB +: 3] = st_q.cur;
            st_d.rd_data[2:0] = st_q.lh_flag;
         end
         `LDD_ADDR_DIAG2: begin
            st_d.rd_data[`LDD_D2_NVFAIL_BIT] = st_q.nv_fail;
            st_d.rd_data[`LDD_D2_NVDONE_BIT] = st_q.nv_done;
            st_d.rd_data[2:0] = st_q.toggle;
         end
         `LDD_ADDR_DIAG1: begin
            st_d.rd_data[`LDD_D1_FAULT_BIT] = st_q.fault;
            st_d.rd_data[`LDD_D1_GOOD_BIT]  = st_q.good;
            st_d.rd_data[2:0] = st_q.last;
         end
         default: st_d.rd_data = `LDD_RST_BYTE;
      endcase
   end

   // Reset is power-on or enable low, which is also off mode
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q    <= '0;
         st_q.gs <= LDD_GS_START;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rd_data            = st_q.rd_data;
   assign gate_supply_fault      = st_q.fault;
   assign gate_supply_good       = st_q.good;
   assign input_supply_status    = vin_s;
   assign gate_driver_enable     = st_q.drv_en;
   assign gate_supply_reg_enable = st_q.drv_en;
   assign vled_update_enable     = st_q.vled_en;
   assign channel_gate_enable    = st_q.gate_en;

   fault_drive_off_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_q.fault |-> !gate_driver_enable && !gate_supply_good
                     && channel_gate_enable == 3'h0)
      else $error("drive active during gate supply fault");

   fault_vled_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_q.fault |-> !vled_update_enable)
      else $error("measurement update during fault");

   fault_sticky_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_q.fault && !clear_errors |=> st_q.fault)
      else $error("fault flag dropped without clear");

   fault_cause_a: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(st_q.fault) |-> $past(vin_s) && !$past(gs_at_s)
         && $past(st_q.gs_cnt) == (($past(st_q.gs) == LDD_GS_START) ? START_LIM
                                   : RUN_LIM))
      else $error("fault set before wait elapsed");

   good_uv_a: assert property (@(posedge clock) disable iff (!rst_b)
      !vin_s |=> !gate_supply_good)
      else $error("good flag held through undervoltage");

   copy_self_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_q.copy[0] && !(reg_wr_en && reg_addr == `LDD_ADDR_COPY && reg_wr_data[0])
      |=> !st_q.copy[0])
      else $error("copy request did not self-clear");

   copy_transfer_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_q.copy[1] && !uv_event && !lh_event[1]
      |=> st_q.last[1] == $past(st_q.cur[1]) && !st_q.cur[1])
      else $error("copy did not move current flag");

   fall_clears_cur_a: assert property (@(posedge clock) disable iff (!rst_b)
      pwm_fall[2] |=> !st_q.cur[2])
      else $error("current flag kept over pwm fall");

   toggle_set_a: assert property (@(posedge clock) disable iff (!rst_b)
      pwm_chg[0] |=> st_q.toggle[0])
      else $error("toggle flag not set");

   diag2_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      reg_wr_en && reg_addr == `LDD_ADDR_DIAG2 && !nv_write_rejected
      && !nv_access_done |=> !st_q.nv_fail && !st_q.nv_done)
      else $error("memory flags not cleared by write");

   headroom_sticky_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_q.lh_flag[0] && !(reg_wr_en && reg_addr == `LDD_ADDR_DIAG3)
      |=> st_q.lh_flag[0])
      else $error("headroom flag dropped without write");

   headroom_cut_a: assert property (@(posedge clock) disable iff (!rst_b)
      channel_on[1] && vin_s && hl_s[1] |=> !channel_gate_enable[1]
      && st_q.lh_flag[1])
      else $error("gate not cut on low headroom");

   good_set_a: assert property (@(posedge clock) disable iff (!rst_b)
      vin_s && gs_at_s && (st_q.gs == LDD_GS_START || st_q.gs == LDD_GS_RUN)
      |=> gate_supply_good)
      else $error("good flag not set at regulated supply");

   last_fall_copy_a: assert property (@(posedge clock) disable iff (!rst_b)
      pwm_fall[0] && !uv_event && !lh_event[0]
      |=> st_q.last[0] == $past(st_q.cur[0]))
      else $error("last-cycle flag not copied on pwm fall");

   last_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      uv_event || lh_event[2] |=> !st_q.last[2])
      else $error("last-cycle flag kept over clear event");

   uv_clears_cur_a: assert property (@(posedge clock) disable iff (!rst_b)
      uv_event |=> st_q.cur == 3'h0)
      else $error("current flags kept over undervoltage");

   cur_set_a: assert property (@(posedge clock) disable iff (!rst_b)
      cur_at_s[1] && !pwm_fall[1] && !uv_event && !st_q.copy[1] && !gate_tmo[1]
      |=> st_q.cur[1])
      else $error("current flag not set at target");

   nv_fail_set_a: assert property (@(posedge clock) disable iff (!rst_b)
      nv_write_rejected |=> st_q.nv_fail)
      else $error("access failed flag not set");

   headroom_resume_a: assert property (@(posedge clock) disable iff (!rst_b)
      channel_on[0] && !hl_s[0] |=> channel_gate_enable[0] == gate_driver_enable)
      else $error("gate not resumed after headroom returned");

   diag1_read_a: assert property (@(posedge clock) disable iff (!rst_b)
      reg_addr == `LDD_ADDR_DIAG1 |=> reg_rd_data ==
         {3'h0, $past(st_q.fault), $past(st_q.good), $past(st_q.last)})
      else $error("diagnostic register 1 read wrong");

   toggle_seen_c: cover property (@(posedge clock) disable iff (!rst_b)
      pwm_chg[1] ##1 st_q.toggle[1]);
   fault_seen_c: cover property (@(posedge clock) disable iff (!rst_b)
      $rose(st_q.fault) ##[1:20] !st_q.fault);
   copy_seen_c: cover property (@(posedge clock) disable iff (!rst_b)
      st_q.cur[0] ##1 st_q.copy[0] ##1 st_q.last[0]);
   headroom_seen_c: cover property (@(posedge clock) disable iff (!rst_b)
      st_q.cut[2] ##[1:20] !st_q.cut[2] && channel_gate_enable[2]);

endmodule

// *** design/ldd_gate_timer.sv ***
/*
 Per-channel watchdog on the gate staying high while PWM is high.
 Assumes gate_high and pwm_high are levels on the core clock.
 Pulses timeout once when the condition has lasted LIMIT cycles.
*/
`timescale 1ns/1ps
`include "ldd_params.svh"

module ldd_gate_timer
   import ldd_pkg::*;
#(
   parameter int unsigned LIMIT = 40000
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic gate_high,
   input  wire logic pwm_high,
   output logic      timeout
);

   localparam logic [`LDD_GATE_CNT_W-1:0] LIM = `LDD_GATE_CNT_W'(LIMIT);

   typedef struct packed {
      logic [`LDD_GATE_CNT_W-1:0] cnt;
      logic                       hit;
   } ldd_gtmr_t;

   ldd_gtmr_t st_q;
   ldd_gtmr_t st_d;

   always_comb begin
      st_d     = st_q;
      st_d.hit = 1'b0;
      if (!(gate_high && pwm_high)) begin
         st_d.cnt = '0;
      end else if (st_q.cnt != LIM) begin
         st_d.cnt = st_q.cnt + 1'b1;
         // Saturating keeps the pulse to one per high phase
         st_d.hit = (st_d.cnt == LIM);
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign timeout = st_q.hit;

   timer_pulse_a: assert property (@(posedge clock) disable iff (!rst_b)
      timeout |-> $past(gate_high) && $past(pwm_high))
      else $error("gate timer fired without gate and pwm high");

endmodule

// *** design/ldd_sync.sv ***
/*
 Two-stage synchroniser for a vector of asynchronous levels.
 Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps

module ldd_sync
   import ldd_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ldd_sync_t;

   ldd_sync_t st_q;
   ldd_sync_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      // First stage feeds only the second stage
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;

endmodule

// *** shared/ldd_params.svh ***
/*
 Constants of the LED driver diagnostic status block: register offsets,
 field positions, reset values and timing figures.
 Assumes a 40 MHz core clock; times are given in microseconds.
*/
`ifndef LDD_PARAMS_SVH
`define LDD_PARAMS_SVH

`define LDD_ADDR_COPY     8'h06
`define LDD_ADDR_DIAG3    8'h35
`define LDD_ADDR_DIAG2    8'h36
`define LDD_ADDR_DIAG1    8'h37

`define LDD_D1_FAULT_BIT  4
`define LDD_D1_GOOD_BIT   3
`define LDD_D2_NVFAIL_BIT 4
`define LDD_D2_NVDONE_BIT 3
`define LDD_D3_CUR_LSB    3

`define LDD_RST_BYTE      8'h00
`define LDD_RST_CH        3'h0

`define LDD_CLK_MHZ       40
`define LDD_START_WAIT_US 12000
`define LDD_RUN_WAIT_US   1000
`define LDD_GATE_HIGH_US  1000

`define LDD_FAULT_CNT_W   19
`define LDD_GATE_CNT_W    16

`endif

// *** shared/ldd_pkg.sv ***
/*
 Types of the LED driver diagnostic status block.
 Assumes ldd_params.svh is on the include path.
*/
`include "ldd_params.svh"

package ldd_pkg;

   typedef enum logic [1:0] {
      LDD_GS_START = 2'b00,
      LDD_GS_RUN   = 2'b01,
      LDD_GS_FAULT = 2'b10
   } ldd_gs_state_t;

   typedef struct packed {
      ldd_gs_state_t                gs;
      logic [`LDD_FAULT_CNT_W-1:0]  gs_cnt;
      logic                         fault;
      logic                         good;
      logic                         drv_en;
      logic                         vled_en;
      logic [2:0]                   pwm_prev;
      logic                         vin_prev;
      logic [2:0]                   copy;
      logic [2:0]                   last;
      logic [2:0]                   cur;
      logic [2:0]                   lh_sample;
      logic [2:0]                   lh_flag;
      logic [2:0]                   cut;
      logic [2:0]                   gate_en;
      logic [2:0]                   toggle;
      logic                         nv_fail;
      logic                         nv_done;
      logic [7:0]                   rd_data;
   } ldd_state_t;

   // Whole cycles at the core clock for a time in microseconds
   function automatic int unsigned ldd_us_to_cycles(input int unsigned us);
      return us * `LDD_CLK_MHZ;
   endfunction

endpackage
